// File: rtl/iprf_top.sv
/*
  Interrupt priority registers and external request flag register, reached
  over AXI4-Lite. Assumes pins are synchronous to REF_CLK, and that the sense
  selects and the exception-handling acknowledge come from the controller.
*/
// Notes on behaviour
// - A bit5 sets ext lines 2,3 level.
// - A bit4 sets ext lines 4,5 level.
// - A bit3 sets watchdog and converter level.
// - A bit2 sets wide timer ch0 level.
// - A bit1 sets wide timer ch1 level.
// - A bit0 sets wide timer ch2 level.
// - B bit7 sets narrow timer ch0,1 level.
// - B bit6 sets narrow timer ch2,3 level.
// - B bits 5,4,1,0 are plain storage.
// - B bit3 sets serial ch0 level.
// - B bit2 sets serial ch1 level.
// - B zero on reset and standby.
// - Flags zero on reset and standby.
// - Flag bits 7,6 read zero, ignore writes.
// - Flag writes can only clear.
// - Clear needs prior read of one.
// - Level mode: acknowledge clears if pin high.
// - Edge mode: acknowledge clears at any pin level, unless a fall in that cycle sets it.
// - Level mode: low pin sets flag.
// - Edge mode: falling pin sets flag.
// - A zero on reset and standby.
// - Sense select picks level or edge.
`timescale 1ns/1ps
`default_nettype none
module iprf_top (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic HW_STANDBY,
  // AXI4-Lite write address and data.
  input wire logic [3:0] S_AXI_AWADDR,
  input wire logic [2:0] S_AXI_AWPROT,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  // AXI4-Lite write response.
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  // AXI4-Lite read.
  input wire logic [3:0] S_AXI_ARADDR,
  input wire logic [2:0] S_AXI_ARPROT,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  // External request pins, active low, and their sense selects.
  input wire logic [5:0] EXT_REQ_PIN_N,
  input wire logic [5:0] EXT_SENSE_SELECT,
  // One-cycle pulse per line when its exception handling is carried out.
  input wire logic [5:0] EXT_REQ_ACK,
  // Outputs to the arbitration logic.
  output logic [5:0] EXT_REQ_FLAG,
  output iprf_pkg::iprf_levels_t PRIO_LEVELS
);

  logic [7:0] priority_level_a;
  logic [7:0] priority_level_b;
  logic [5:0] external_request_flags;
  logic [5:0] read_one_seen;
  logic [5:0] pin_prev;
  logic aw_held;
  logic w_held;
  logic [3:0] aw_addr;
  logic [7:0] w_data;
  logic w_lane0;

  // Write channel: address and data may be taken in either order.
  wire aw_take = S_AXI_AWVALID && !aw_held && !S_AXI_BVALID;
  wire w_take = S_AXI_WVALID && !w_held && !S_AXI_BVALID;
  wire [3:0] wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
  wire [7:0] wr_data = w_held ? w_data : S_AXI_WDATA[7:0];
  wire wr_lane0 = w_held ? w_lane0 : S_AXI_WSTRB[0];
  wire wr_fire = (aw_held || aw_take) && (w_held || w_take);
  wire wr_hit = (wr_addr == iprf_pkg::OFS_PRIO_A) || (wr_addr == iprf_pkg::OFS_PRIO_B) ||
                (wr_addr == iprf_pkg::OFS_FLAGS);
  wire wr_en = wr_fire && wr_lane0;
  wire wr_a = wr_en && (wr_addr == iprf_pkg::OFS_PRIO_A);
  wire wr_b = wr_en && (wr_addr == iprf_pkg::OFS_PRIO_B);
  wire wr_f = wr_en && (wr_addr == iprf_pkg::OFS_FLAGS);

  assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;

  // Read channel.
  wire rd_take = S_AXI_ARVALID && !S_AXI_RVALID;
  wire rd_a = S_AXI_ARADDR == iprf_pkg::OFS_PRIO_A;
  wire rd_b = S_AXI_ARADDR == iprf_pkg::OFS_PRIO_B;
  wire rd_f = S_AXI_ARADDR == iprf_pkg::OFS_FLAGS;
  wire [7:0] rd_value = rd_a ? priority_level_a :
                        rd_b ? priority_level_b :
                        rd_f ? ({2'h0, external_request_flags} & iprf_pkg::FLAGS_MASK) : 8'h00;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  // Flag set and clear terms.
  wire [5:0] pin_low = ~EXT_REQ_PIN_N;
  wire [5:0] fall = pin_prev & ~EXT_REQ_PIN_N;
  wire [5:0] set_level = ~EXT_SENSE_SELECT & pin_low;
  wire [5:0] set_edge = EXT_SENSE_SELECT & fall;
  wire [5:0] set_any = set_level | set_edge;
  wire [5:0] ack_clr = EXT_REQ_ACK & (EXT_SENSE_SELECT | EXT_REQ_PIN_N);
  // A zero bit clears only where a one was read before; a one bit never sets.
  wire [5:0] sw_clr = wr_f ? (~wr_data[5:0] & read_one_seen) : 6'h00;
  wire [5:0] next_flags = (external_request_flags & ~(ack_clr | sw_clr)) | set_any;
  // A read of the flag register arms clearing for each bit then seen at one.
  wire [5:0] next_read_one = (rd_take && rd_f) ?
                             (read_one_seen | external_request_flags) :
                             (read_one_seen & ~sw_clr & external_request_flags);

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      priority_level_a <= iprf_pkg::RST_PRIO_A;
      priority_level_b <= iprf_pkg::RST_PRIO_B;
    end else if (HW_STANDBY) begin
      priority_level_a <= iprf_pkg::RST_PRIO_A;
      priority_level_b <= iprf_pkg::RST_PRIO_B;
    end else begin
      if (wr_a) begin
        priority_level_a <= wr_data;
      end
      if (wr_b) begin
        priority_level_b <= wr_data;
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      external_request_flags <= iprf_pkg::RST_FLAGS[5:0];
      read_one_seen <= 6'h00;
      pin_prev <= 6'h3F;
    end else if (HW_STANDBY) begin
      external_request_flags <= iprf_pkg::RST_FLAGS[5:0];
      read_one_seen <= 6'h00;
      pin_prev <= EXT_REQ_PIN_N;
    end else begin
      external_request_flags <= next_flags;
      read_one_seen <= next_read_one;
      pin_prev <= EXT_REQ_PIN_N;
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 8'h00;
      w_lane0 <= 1'b0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= iprf_pkg::RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= wr_hit ? iprf_pkg::RESP_OKAY : iprf_pkg::RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= S_AXI_AWADDR;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= S_AXI_WDATA[7:0];
          w_lane0 <= S_AXI_WSTRB[0];
        end
        if (S_AXI_BVALID && S_AXI_BREADY) begin
          S_AXI_BVALID <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or posedge RESET) begin
    if (RESET) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0000_0000;
      S_AXI_RRESP <= iprf_pkg::RESP_OKAY;
    end else if (rd_take) begin
      S_AXI_RVALID <= 1'b1;
      S_AXI_RDATA <= {24'h00_0000, rd_value};
      S_AXI_RRESP <= (rd_a || rd_b || rd_f) ? iprf_pkg::RESP_OKAY : iprf_pkg::RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      S_AXI_RVALID <= 1'b0;
    end
  end

  assign EXT_REQ_FLAG = external_request_flags;

  // Level outputs; the arbiter serves pending level 1 before level 0.
  assign PRIO_LEVELS.ext_line_0 = priority_level_a[iprf_pkg::BIT_EXT_LINE_0];
  assign PRIO_LEVELS.ext_line_1 = priority_level_a[iprf_pkg::BIT_EXT_LINE_1];
  assign PRIO_LEVELS.ext_lines_2_3 = priority_level_a[iprf_pkg::BIT_EXT_LINES_2_3];
  assign PRIO_LEVELS.ext_lines_4_5 = priority_level_a[iprf_pkg::BIT_EXT_LINES_4_5];
  assign PRIO_LEVELS.watchdog_converter = priority_level_a[iprf_pkg::BIT_WATCHDOG_CONVERTER];
  assign PRIO_LEVELS.wide_timer_ch0 = priority_level_a[iprf_pkg::BIT_WIDE_TIMER_CH0];
  assign PRIO_LEVELS.wide_timer_ch1 = priority_level_a[iprf_pkg::BIT_WIDE_TIMER_CH1];
  assign PRIO_LEVELS.wide_timer_ch2 = priority_level_a[iprf_pkg::BIT_WIDE_TIMER_CH2];
  assign PRIO_LEVELS.narrow_timer_ch01 = priority_level_b[iprf_pkg::BIT_NARROW_TIMER_CH01];
  assign PRIO_LEVELS.narrow_timer_ch23 = priority_level_b[iprf_pkg::BIT_NARROW_TIMER_CH23];
  assign PRIO_LEVELS.serial_ch0 = priority_level_b[iprf_pkg::BIT_SERIAL_CH0];
  assign PRIO_LEVELS.serial_ch1 = priority_level_b[iprf_pkg::BIT_SERIAL_CH1];

  // Protection bits, upper write data bits and upper strobe bits are not used.
  wire unused_ok = &{1'b0, S_AXI_AWPROT, S_AXI_ARPROT, S_AXI_WDATA[31:8], S_AXI_WSTRB[3:1]};

endmodule : iprf_top
`default_nettype wire

// File: rtl/iprf_pkg.sv
/*
  Package of the interrupt priority and request flag block: register offsets,
  field positions, reset values and the carrier types shared by the block.
  Assumes a 32-bit AXI4-Lite register bus with one register per aligned word.
*/
package iprf_pkg;

  localparam int unsigned NUM_EXT = 6;

  // Byte addresses of the three registers.
  localparam logic [3:0] OFS_PRIO_A = 4'h0;
  localparam logic [3:0] OFS_PRIO_B = 4'h4;
  localparam logic [3:0] OFS_FLAGS = 4'h8;

  // Reset values.
  localparam logic [7:0] RST_PRIO_A = 8'h00;
  localparam logic [7:0] RST_PRIO_B = 8'h00;
  localparam logic [7:0] RST_FLAGS = 8'h00;

  // Field positions in priority_level_a.
  localparam int unsigned BIT_EXT_LINE_0 = 7;
  localparam int unsigned BIT_EXT_LINE_1 = 6;
  localparam int unsigned BIT_EXT_LINES_2_3 = 5;
  localparam int unsigned BIT_EXT_LINES_4_5 = 4;
  localparam int unsigned BIT_WATCHDOG_CONVERTER = 3;
  localparam int unsigned BIT_WIDE_TIMER_CH0 = 2;
  localparam int unsigned BIT_WIDE_TIMER_CH1 = 1;
  localparam int unsigned BIT_WIDE_TIMER_CH2 = 0;

  // Field positions in priority_level_b.
  localparam int unsigned BIT_NARROW_TIMER_CH01 = 7;
  localparam int unsigned BIT_NARROW_TIMER_CH23 = 6;
  localparam int unsigned BIT_SERIAL_CH0 = 3;
  localparam int unsigned BIT_SERIAL_CH1 = 2;

  // Only the low six bits of the flag register are implemented.
  localparam logic [7:0] FLAGS_MASK = 8'h3F;

  // AXI4-Lite responses.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Priority level of every source group, one bit each, 1 is high.
  typedef struct packed {
    logic ext_line_0;
    logic ext_line_1;
    logic ext_lines_2_3;
    logic ext_lines_4_5;
    logic watchdog_converter;
    logic wide_timer_ch0;
    logic wide_timer_ch1;
    logic wide_timer_ch2;
    logic narrow_timer_ch01;
    logic narrow_timer_ch23;
    logic serial_ch0;
    logic serial_ch1;
  } iprf_levels_t;

endpackage : iprf_pkg

// File: testbench/iprf_checker.sv
/* Checker of the priority and flag block.
   Assumes it is bound to iprf_top and sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module iprf_checker (
  // Clock and reset.
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic HW_STANDBY,
  // Bus.
  input wire logic S_AXI_ARVALID,
  input wire logic S_AXI_ARREADY,
  input wire logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA,
  input wire logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [1:0] S_AXI_BRESP,
  // Requests.
  input wire logic [5:0] EXT_REQ_PIN_N,
  input wire logic [5:0] EXT_SENSE_SELECT,
  input wire logic [5:0] EXT_REQ_ACK,
  input wire logic [5:0] EXT_REQ_FLAG,
  input wire iprf_pkg::iprf_levels_t PRIO_LEVELS
);
  logic [5:0] pin_q;
  wire logic [5:0] sel = EXT_SENSE_SELECT;
  wire logic [5:0] set_now = ~EXT_REQ_PIN_N & (~sel | pin_q);
  wire logic [5:0] clr_now = EXT_REQ_ACK & (sel | EXT_REQ_PIN_N) & ~set_now;
  always_ff @(posedge REF_CLK or posedge RESET)
    if (RESET) pin_q <= 6'h3F;
    else pin_q <= EXT_REQ_PIN_N;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  sequence ar_taken; S_AXI_ARVALID && S_AXI_ARREADY; endsequence
  sequence b_waiting; S_AXI_BVALID && !S_AXI_BREADY; endsequence
  chk_flag_sets: assert property (
    !HW_STANDBY |=> ($past(set_now) & ~EXT_REQ_FLAG) == 6'h0) else $error("flag not set");
  chk_ack_clears: assert property (
    !HW_STANDBY |=> ($past(clr_now) & EXT_REQ_FLAG) == 6'h0) else $error("flag not cleared");
  chk_only_clears: assert property (
    1'b1 |=> (EXT_REQ_FLAG & ~$past(EXT_REQ_FLAG) & ~$past(set_now)) == 6'h0)
    else $error("flag set without request");
  chk_standby_levels: assert property (
    HW_STANDBY |=> PRIO_LEVELS == 12'h000) else $error("levels kept in standby");
  chk_standby_flags: assert property (
    HW_STANDBY |=> EXT_REQ_FLAG == 6'h00) else $error("flags kept in standby");
  chk_levels_change: assert property (
    $changed(PRIO_LEVELS) |-> $rose(S_AXI_BVALID) || $past(HW_STANDBY))
    else $error("levels changed without write");
  chk_read_answer: assert property (ar_taken |=> S_AXI_RVALID) else $error("read late");
  chk_bresp_holds: assert property (b_waiting |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response dropped");
  chk_rdata_holds: assert property (
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read data dropped");
endmodule : iprf_checker
bind iprf_top iprf_checker u_iprf_checker (.REF_CLK, .RESET, .HW_STANDBY, .S_AXI_ARVALID,
  .S_AXI_ARREADY, .S_AXI_RVALID, .S_AXI_RREADY, .S_AXI_RDATA, .S_AXI_BVALID, .S_AXI_BREADY,
  .S_AXI_BRESP, .EXT_REQ_PIN_N, .EXT_SENSE_SELECT, .EXT_REQ_ACK, .EXT_REQ_FLAG, .PRIO_LEVELS);
`default_nettype wire

// File: testbench/iprf_partner.sv
/* Model of the request pins and the exception acknowledge.
   Assumes the bench commands it one clock edge ahead. */
`timescale 1ns/1ps
`default_nettype none
module iprf_partner (
  // Clock and commands.
  input wire logic clk,
  input wire logic [5:0] low_cmd,
  input wire logic [5:0] ack_cmd,
  // Toward the block.
  output var logic [5:0] pin_n,
  output var logic [5:0] ack
);
  logic [5:0] cmd_q;
  initial {pin_n, ack, cmd_q} = {6'h3F, 12'h000};
  // Each newly raised command bit gives a single acknowledge pulse.
  always @(posedge clk) begin
    pin_n <= ~low_cmd;
    ack <= ack_cmd & ~cmd_q;
    cmd_q <= ack_cmd;
  end
endmodule : iprf_partner
`default_nettype wire

// File: testbench/tb_irq_priority_and_flag_logic.sv
/* Self-checking bench of the priority and flag block.
   Assumes iprf_partner drives the pins and the acknowledge. */
`timescale 1ns/1ps
`default_nettype none
module tb_irq_priority_and_flag_logic;
  logic clk = 0, rst = 1, stby = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
  logic [3:0] awa = 4'h0, ara = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [5:0] sel = 6'h0, low = 6'h0, ackc = 6'h0;
  wire logic awr, wr, bv, arr, rv;
  wire logic [1:0] br, rr;
  wire logic [31:0] rdata;
  wire logic [5:0] pin_n, ack, flag;
  wire iprf_pkg::iprf_levels_t lev;
  int fails = 0, compares = 0;
  localparam logic [23:0] rows [8] = '{24'h020200, 24'h010100, 24'h008080, 24'h007070,
    24'h480078, 24'h440074, 24'h433070, 24'h40C073};
  iprf_top u_iprf_top (.REF_CLK(clk), .RESET(rst), .HW_STANDBY(stby), .S_AXI_AWADDR(awa),
    .S_AXI_AWPROT(3'h0), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wr), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bre), .S_AXI_ARADDR(ara), .S_AXI_ARPROT(3'h0),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rr),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .EXT_REQ_PIN_N(pin_n), .EXT_SENSE_SELECT(sel),
    .EXT_REQ_ACK(ack), .EXT_REQ_FLAG(flag), .PRIO_LEVELS(lev));
  iprf_partner u_iprf_partner (.clk(clk), .low_cmd(low), .ack_cmd(ackc), .pin_n(pin_n),
    .ack(ack));
  initial forever #12.5 clk = ~clk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  task automatic look(input logic [5:0] f);
    repeat (3) @(posedge clk);
    @(negedge clk);
    cmp({26'h0, flag}, {26'h0, f});
  endtask : look
  // Ready is raised a cycle after valid so that the held answer is exercised.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     input logic [1:0] r);
    logic ta, tw, v, done;
    logic [31:0] got;
    logic [1:0] resp;
    @(posedge clk);
    if (w) {awa, wd, awv, wv} <= {a, 24'h0, d, 2'h3};
    else {ara, arv} <= {a, 1'b1};
    done = 1'b0;
    while (!done) begin
      @(negedge clk);
      ta = (awv & awr) | (arv & arr);
      tw = wv & wr;
      v = w ? bv : rv;
      done = v & (w ? bre : rre);
      got = rdata;
      resp = w ? br : rr;
      @(posedge clk);
      if (ta) {awv, arv} <= 2'h0;
      if (tw) wv <= 1'b0;
      if (v && !done) {bre, rre} <= {w, !w};
    end
    {bre, rre} <= 2'h0;
    cmp({30'h0, resp}, {30'h0, r});
    if (!w) cmp(got, {24'h0, d});
  endtask : bus
  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (5000) @(posedge clk);
    fails++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, 4'h0, 8'h00, 2'h0);
    bus(1'b0, 4'h4, 8'h00, 2'h0);
    bus(1'b0, 4'h8, 8'h00, 2'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, rows[i][23:20], rows[i][19:12], 2'h0);
      bus(1'b0, rows[i][23:20], rows[i][19:12], 2'h0);
      cmp({20'h0, lev}, {20'h0, rows[i][11:0]});
    end
    bus(1'b1, 4'hC, 8'hFF, 2'h2);
    bus(1'b0, 4'hC, 8'h00, 2'h2);
    @(posedge clk);
    low <= 6'h01;
    @(posedge clk);
    low <= 6'h00;
    look(6'h01);
    bus(1'b1, 4'h8, 8'h00, 2'h0);
    look(6'h01);
    @(posedge clk);
    ackc <= 6'h01;
    look(6'h00);
    @(posedge clk);
    {sel, low} <= {6'h06, 6'h06};
    @(posedge clk);
    low <= 6'h00;
    look(6'h06);
    bus(1'b0, 4'h8, 8'h06, 2'h0);
    bus(1'b1, 4'h8, 8'hFD, 2'h0);
    bus(1'b0, 4'h8, 8'h04, 2'h0);
    @(posedge clk);
    ackc <= 6'h04;
    look(6'h00);
    bus(1'b1, 4'h8, 8'hFF, 2'h0);
    bus(1'b0, 4'h8, 8'h00, 2'h0);
    bus(1'b1, 4'h0, 8'hFF, 2'h0);
    @(posedge clk);
    {sel, low} <= {6'h00, 6'h20};
    look(6'h20);
    @(posedge clk);
    stby <= 1'b1;
    look(6'h00);
    cmp({20'h0, lev}, 32'h0);
    @(posedge clk);
    low <= 6'h00;
    repeat (3) @(posedge clk);
    stby <= 1'b0;
    bus(1'b0, 4'h0, 8'h00, 2'h0);
    wrap_up();
  end
endmodule : tb_irq_priority_and_flag_logic
`default_nettype wire
